// ### verilog/ihx_top.sv
// Two-wire host byte engine: transmit, receive, conditions and arbitration
//
// Function
// - Buffer write sets buffer-full; cleared after eighth bit shifts out.
// - Buffer write while busy sets write-collision and is discarded.
// - Acknowledge-status clears on ACK, sets on NACK.
// - Transmission begins as soon as the buffer is written.
// - Ninth clock samples acknowledge and raises the serial interrupt flag.
// - Start, stop and restart completion raise the serial interrupt flag.
// - Receive-enable only starts reception when idle, otherwise ignored.
// - Reception toggles clock per rollover and shifts the data line in.
// - After eighth falling edge: copy byte, flag, clear enable, hold clock low.
// - Reading the data buffer clears buffer-full.
// - Byte arriving while buffer-full still set raises receive-overflow.
// - Start and stop detect flags clear on reset and disable.
// - Busy or collided host keeps watching and flags an observed stop.
// - Released data read low while clock high is a bus collision.
// - Arbitration checked in address, data, start, restart, acknowledge.
// - Transmit collision halts shift, clears buffer-full, releases lines.
// - Condition collision aborts it, releases lines, clears its enable.
// - After a collision a new write restarts from the first bit.
// - After the eighth bit the data line is released for acknowledge.
// - Baud generator reloads from divider; values below three invalid.
`default_nettype none
module ihx_top #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Register port
  input wire ihx_pkg::ihx_req_t i_req,
  output logic [7:0] o_rdata,
  // Clock line, open drain
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  // Data line, open drain
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // Status levels
  output logic o_serial_irq_flag,
  output logic o_bus_collision_flag
);
  ihx_pkg::ihx_state_t state_q;
  logic [1:0] phase_q;
  logic [3:0] bit_q;
  logic [7:0] port_shift_register_q;
  logic scl_drv_q, sda_drv_q;
  logic ev_done_q, ev_irq_q, ev_bcl_q, ev_bcl_tx_q, ev_tx8_q, ev_rx_q, ev_ack_q, ack_val_q;
  logic [7:0] serial_data_buffer_q, divider_register_q, rdata_q;
  logic port_en_q;
  logic begin_condition_enable_q, restart_enable_q, end_condition_enable_q;
  logic receive_enable_q, ack_sequence_enable_q, ack_data_value_q;
  logic buffer_full_flag_q, write_collision_flag_q, ack_status_flag_q, receive_overflow_flag_q;
  logic serial_irq_flag_q, bus_collision_flag_q, start_seen_q, stop_seen_q;
  logic scl_p_q, sda_p_q;
  logic tick, run, stall, idle, buf_wr, buf_wr_ok, buf_rd, ctrl_wr, stat_wr;
  logic bus_start, bus_stop;

  // Released line that reads low means another party won the bit
  function automatic logic lost_arb(input logic drive_low, input logic line);
    lost_arb = !drive_low && !line;
  endfunction : lost_arb

  assign idle = (state_q == ihx_pkg::S_IDLE);
  assign buf_wr = i_req.wr && (i_req.addr == ihx_pkg::A_DATA);
  assign buf_wr_ok = buf_wr && idle && port_en_q;
  assign buf_rd = i_req.rd && (i_req.addr == ihx_pkg::A_DATA);
  // Condition bits are refused mid-sequence since events cannot be queued
  assign ctrl_wr = i_req.wr && (i_req.addr == ihx_pkg::A_CTRL2) && idle && !ev_done_q;
  assign stat_wr = i_req.wr && (i_req.addr == ihx_pkg::A_STAT);
  // Clock stretching: a released clock held low by a client pauses counting, except during a start condition
  assign stall = !scl_drv_q && !i_scl && (state_q != ihx_pkg::S_START);
  assign run = !idle && !stall;

  ihx_baud_gen #(
    .DIV_W(DIV_W)
  ) u_baud_generator (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_run(run),
    .i_div(divider_register_q[DIV_W-1:0]),
    .o_tick(tick)
  );

  // Open drain: data is always low, only the enables move
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  assign o_scl_oe = scl_drv_q;
  assign o_sda_oe = sda_drv_q;
  assign o_rdata = rdata_q;
  assign o_serial_irq_flag = serial_irq_flag_q;
  assign o_bus_collision_flag = bus_collision_flag_q;

  // Host sequencer; one-cycle event pulses feed the flag logic
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || !port_en_q)
    begin
      state_q <= ihx_pkg::S_IDLE;
      phase_q <= 2'h0;
      bit_q <= 4'h0;
      port_shift_register_q <= 8'h00;
      scl_drv_q <= 1'b0;
      sda_drv_q <= 1'b0;
      {ev_done_q, ev_irq_q, ev_bcl_q, ev_bcl_tx_q, ev_tx8_q, ev_rx_q, ev_ack_q, ack_val_q} <= 8'h00;
    end
    else
    begin
      {ev_done_q, ev_irq_q, ev_bcl_q, ev_bcl_tx_q, ev_tx8_q, ev_rx_q, ev_ack_q} <= 7'h00;
      case (state_q)
        ihx_pkg::S_IDLE:
        begin
          phase_q <= 2'h0;
          bit_q <= 4'h0;
          if (buf_wr_ok)
          begin
            // Any accepted write starts afresh at the first bit
            port_shift_register_q <= i_req.wdata;
            sda_drv_q <= !i_req.wdata[7];
            scl_drv_q <= 1'b1;
            state_q <= ihx_pkg::S_TX;
          end
          else if (!ev_done_q && begin_condition_enable_q)
          begin
            if (!i_scl || !i_sda)
            begin
              // Either line already low: start aborted at once
              ev_bcl_q <= 1'b1;
              ev_done_q <= 1'b1;
            end
            else
            begin
              scl_drv_q <= 1'b0;
              sda_drv_q <= 1'b0;
              state_q <= ihx_pkg::S_START;
            end
          end
          else if (!ev_done_q && restart_enable_q)
          begin
            scl_drv_q <= 1'b1;
            sda_drv_q <= 1'b0;
            state_q <= ihx_pkg::S_RESTART;
          end
          else if (!ev_done_q && end_condition_enable_q)
          begin
            scl_drv_q <= 1'b1;
            sda_drv_q <= 1'b1;
            state_q <= ihx_pkg::S_STOP;
          end
          else if (!ev_done_q && receive_enable_q)
          begin
            scl_drv_q <= 1'b1;
            sda_drv_q <= 1'b0;
            state_q <= ihx_pkg::S_RX;
          end
          else if (!ev_done_q && ack_sequence_enable_q)
          begin
            scl_drv_q <= 1'b1;
            sda_drv_q <= !ack_data_value_q;
            state_q <= ihx_pkg::S_ACK;
          end
        end
        ihx_pkg::S_TX:
        begin
          if (phase_q == 2'h0)
          begin
            if (tick)
            begin
              scl_drv_q <= 1'b0;
              phase_q <= 2'h1;
            end
          end
          else if (bit_q != ihx_pkg::ACK_BIT && i_scl && lost_arb(sda_drv_q, i_sda))
          begin
            // Lost a bit: halt and release both lines
            state_q <= ihx_pkg::S_IDLE;
            scl_drv_q <= 1'b0;
            sda_drv_q <= 1'b0;
            ev_bcl_q <= 1'b1;
            ev_bcl_tx_q <= 1'b1;
            ev_done_q <= 1'b1;
          end
          else if (tick)
          begin
            scl_drv_q <= 1'b1;
            phase_q <= 2'h0;
            if (bit_q == ihx_pkg::ACK_BIT)
            begin
              // Ninth falling edge: keep clock low until the next write
              ev_ack_q <= 1'b1;
              ack_val_q <= i_sda;
              ev_irq_q <= 1'b1;
              ev_done_q <= 1'b1;
              state_q <= ihx_pkg::S_IDLE;
            end
            else
            begin
              bit_q <= bit_q + 4'h1;
              port_shift_register_q <= {port_shift_register_q[6:0], 1'b0};
              if (bit_q == ihx_pkg::LAST_DATA_BIT)
              begin
                sda_drv_q <= 1'b0;
                ev_tx8_q <= 1'b1;
              end
              else
                sda_drv_q <= !port_shift_register_q[6];
            end
          end
        end
        ihx_pkg::S_RX:
        begin
          if (tick && phase_q == 2'h0)
          begin
            scl_drv_q <= 1'b0;
            phase_q <= 2'h1;
          end
          else if (tick)
          begin
            scl_drv_q <= 1'b1;
            phase_q <= 2'h0;
            port_shift_register_q <= {port_shift_register_q[6:0], i_sda};
            bit_q <= bit_q + 4'h1;
            if (bit_q == ihx_pkg::LAST_DATA_BIT)
            begin
              ev_rx_q <= 1'b1;
              ev_irq_q <= 1'b1;
              ev_done_q <= 1'b1;
              state_q <= ihx_pkg::S_IDLE;
            end
          end
        end
        ihx_pkg::S_ACK, ihx_pkg::S_START, ihx_pkg::S_RESTART, ihx_pkg::S_STOP:
        begin
          // Collision cases of the timed conditions
          if ((state_q == ihx_pkg::S_ACK && phase_q == 2'h1 && i_scl && lost_arb(sda_drv_q, i_sda))
              || (state_q == ihx_pkg::S_START && phase_q == 2'h0 && !i_scl)
              || (state_q == ihx_pkg::S_RESTART && phase_q == 2'h1 && i_scl && !i_sda)
              || (state_q == ihx_pkg::S_STOP && phase_q == 2'h2 && tick && !i_sda))
          begin
            state_q <= ihx_pkg::S_IDLE;
            scl_drv_q <= 1'b0;
            sda_drv_q <= 1'b0;
            ev_bcl_q <= 1'b1;
            ev_done_q <= 1'b1;
          end
          else if (tick)
          begin
            phase_q <= phase_q + 2'h1;
            case (state_q)
              ihx_pkg::S_START:
                if (phase_q == 2'h0)
                  sda_drv_q <= 1'b1;
                else
                  scl_drv_q <= 1'b1;
              ihx_pkg::S_RESTART:
                if (phase_q == 2'h0)
                  scl_drv_q <= 1'b0;
                else if (phase_q == 2'h1)
                  sda_drv_q <= 1'b1;
                else
                  scl_drv_q <= 1'b1;
              ihx_pkg::S_STOP:
                if (phase_q == 2'h0)
                  scl_drv_q <= 1'b0;
                else if (phase_q == 2'h1)
                  sda_drv_q <= 1'b0;
              default:
                scl_drv_q <= !scl_drv_q;
            endcase
            // Condition finished: flag it and return to idle
            if ((state_q == ihx_pkg::S_STOP && phase_q == 2'h3)
                || (state_q == ihx_pkg::S_RESTART && phase_q == 2'h2)
                || ((state_q == ihx_pkg::S_START || state_q == ihx_pkg::S_ACK) && phase_q == 2'h1))
            begin
              ev_irq_q <= 1'b1;
              ev_done_q <= 1'b1;
              state_q <= ihx_pkg::S_IDLE;
            end
          end
        end
        default:
          state_q <= ihx_pkg::S_IDLE;
      endcase
    end
  end

  // Software registers; condition enables self-clear when their sequence ends
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      divider_register_q <= ihx_pkg::DIV_RST;
      port_en_q <= 1'b0;
      {begin_condition_enable_q, restart_enable_q, end_condition_enable_q} <= 3'h0;
      {receive_enable_q, ack_sequence_enable_q, ack_data_value_q} <= 3'h0;
    end
    else
    begin
      if (i_req.wr && i_req.addr == ihx_pkg::A_DIV)
        divider_register_q <= i_req.wdata;
      if (i_req.wr && i_req.addr == ihx_pkg::A_CFG)
        port_en_q <= i_req.wdata[ihx_pkg::CFG_EN];
      if (i_req.wr && i_req.addr == ihx_pkg::A_CTRL2)
        ack_data_value_q <= i_req.wdata[ihx_pkg::C2_ACKDATA];
      if (ctrl_wr)
      begin
        begin_condition_enable_q <= i_req.wdata[ihx_pkg::C2_BEGIN];
        restart_enable_q <= i_req.wdata[ihx_pkg::C2_RESTART];
        end_condition_enable_q <= i_req.wdata[ihx_pkg::C2_END];
        receive_enable_q <= i_req.wdata[ihx_pkg::C2_RCV];
        ack_sequence_enable_q <= i_req.wdata[ihx_pkg::C2_ACKSEQ];
      end
      else if (ev_done_q || !port_en_q)
      begin
        {begin_condition_enable_q, restart_enable_q, end_condition_enable_q} <= 3'h0;
        {receive_enable_q, ack_sequence_enable_q} <= 2'h0;
      end
    end
  end

  // Data buffer: software writes only when idle, received bytes land here
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      serial_data_buffer_q <= 8'h00;
    else if (ev_rx_q)
      serial_data_buffer_q <= port_shift_register_q;
    else if (buf_wr_ok)
      serial_data_buffer_q <= i_req.wdata;
  end

  // Status flags: a hardware set always beats a same-cycle software clear
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      {buffer_full_flag_q, write_collision_flag_q, ack_status_flag_q, receive_overflow_flag_q} <= 4'h0;
      {serial_irq_flag_q, bus_collision_flag_q} <= 2'h0;
    end
    else
    begin
      buffer_full_flag_q <= (buffer_full_flag_q && !(ev_tx8_q || ev_bcl_tx_q || buf_rd))
                            || ev_rx_q || buf_wr_ok;
      // Write-collision never clears itself; software must clear it
      write_collision_flag_q <= (write_collision_flag_q && !(stat_wr && i_req.wdata[ihx_pkg::ST_WRITE_COLLISION_FLAG]))
                                || (buf_wr && !buf_wr_ok);
      receive_overflow_flag_q <= (receive_overflow_flag_q && !(stat_wr && i_req.wdata[ihx_pkg::ST_OVF]))
                                 || (ev_rx_q && buffer_full_flag_q);
      serial_irq_flag_q <= (serial_irq_flag_q && !(stat_wr && i_req.wdata[ihx_pkg::ST_IRQ]))
                           || ev_irq_q || (bus_stop && state_q != ihx_pkg::S_STOP);
      bus_collision_flag_q <= (bus_collision_flag_q && !(stat_wr && i_req.wdata[ihx_pkg::ST_BCL]))
                              || ev_bcl_q;
      if (ev_ack_q)
        ack_status_flag_q <= ack_val_q;
    end
  end

  // Bus monitor: start and stop seen on the lines, whoever made them
  assign bus_start = scl_p_q && i_scl && sda_p_q && !i_sda;
  assign bus_stop = scl_p_q && i_scl && !sda_p_q && i_sda;
  always_ff @(posedge i_ref_clk)
  begin
    scl_p_q <= i_scl;
    sda_p_q <= i_sda;
    if (i_srst || !port_en_q)
    begin
      start_seen_q <= 1'b0;
      stop_seen_q <= 1'b0;
    end
    else if (bus_start)
    begin
      start_seen_q <= 1'b1;
      stop_seen_q <= 1'b0;
    end
    else if (bus_stop)
    begin
      start_seen_q <= 1'b0;
      stop_seen_q <= 1'b1;
    end
  end

  // Read data appear in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      rdata_q <= 8'h00;
    else if (i_req.rd)
      case (i_req.addr)
        ihx_pkg::A_DATA: rdata_q <= serial_data_buffer_q;
        ihx_pkg::A_DIV: rdata_q <= divider_register_q;
        ihx_pkg::A_CTRL2: rdata_q <= {2'h0, ack_data_value_q, ack_sequence_enable_q, receive_enable_q,
                                      end_condition_enable_q, restart_enable_q, begin_condition_enable_q};
        ihx_pkg::A_STAT: rdata_q <= {stop_seen_q, start_seen_q, bus_collision_flag_q, serial_irq_flag_q,
                                     receive_overflow_flag_q, ack_status_flag_q, write_collision_flag_q,
                                     buffer_full_flag_q};
        ihx_pkg::A_CFG: rdata_q <= {7'h00, port_en_q};
        default: rdata_q <= 8'h00;
      endcase
    else
      rdata_q <= 8'h00;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  chk_bf_on_write: assert property (buf_wr_ok |=> buffer_full_flag_q ##1 1'b1)
    else $error("buffer write did not set buffer full");
  chk_write_collision_flag_discard: assert property (buf_wr && !idle |=> write_collision_flag_q
    && $stable(serial_data_buffer_q))
    else $error("busy buffer write not refused");
  chk_tx_first_bit: assert property (buf_wr_ok |=> state_q == ihx_pkg::S_TX
    && sda_drv_q == !$past(i_req.wdata[7]) && scl_drv_q)
    else $error("transmission did not start on buffer write");
  chk_ack_sampled: assert property (ev_ack_q |=> ack_status_flag_q == $past(ack_val_q)
    && serial_irq_flag_q)
    else $error("acknowledge status or flag wrong after ninth clock");
  chk_ack_release: assert property (state_q == ihx_pkg::S_TX && bit_q == ihx_pkg::ACK_BIT
    |-> !sda_drv_q)
    else $error("data line driven during acknowledge bit");
  chk_rcv_refused: assert property (i_req.wr && i_req.addr == ihx_pkg::A_CTRL2 && !idle
    && !receive_enable_q |=> !receive_enable_q)
    else $error("receive enable accepted while busy");
  chk_rx_done: assert property (ev_rx_q |=> buffer_full_flag_q && serial_irq_flag_q
    && !receive_enable_q && scl_drv_q && idle)
    else $error("receive completion actions missing");
  chk_rd_clears: assert property (buf_rd && !ev_rx_q && !buf_wr_ok |=> !buffer_full_flag_q)
    else $error("buffer read did not clear buffer full");
  chk_overflow_set: assert property (ev_rx_q && buffer_full_flag_q |=> receive_overflow_flag_q)
    else $error("overflow not flagged");
  chk_detect_clear: assert property (!port_en_q |=> !start_seen_q && !stop_seen_q)
    else $error("detect flags survive disable");
  chk_collide_idle: assert property (ev_bcl_q |-> idle && !scl_drv_q && !sda_drv_q
    ##1 bus_collision_flag_q && !begin_condition_enable_q && !restart_enable_q)
    else $error("collision did not release lines and go idle");
  chk_tx_bf_clear: assert property (ev_bcl_tx_q && !buf_wr_ok |=> !buffer_full_flag_q)
    else $error("collision in transmit left buffer full");

  cov_tx_byte: cover property (ev_ack_q);
  cov_rx_byte: cover property (ev_rx_q);
  cov_collision: cover property (ev_bcl_q);
  cov_stop_seen: cover property (bus_stop && stop_seen_q == 1'b0);
endmodule : ihx_top
`default_nettype wire

// ### verilog/ihx_pkg.sv
// Shared constants, register map and carrier types of the two-wire host port
`default_nettype none
package ihx_pkg;
  // Register word offsets on the plain register port
  localparam int ADDR_W = 3;
  localparam logic [2:0] A_DATA = 3'h0; // serial_data_buffer
  localparam logic [2:0] A_DIV = 3'h1; // divider_register
  localparam logic [2:0] A_CTRL2 = 3'h2; // control_register_two
  localparam logic [2:0] A_STAT = 3'h3; // status flags
  localparam logic [2:0] A_CFG = 3'h4; // port enable
  // control_register_two fields
  localparam int C2_BEGIN = 0;
  localparam int C2_RESTART = 1;
  localparam int C2_END = 2;
  localparam int C2_RCV = 3;
  localparam int C2_ACKSEQ = 4;
  localparam int C2_ACKDATA = 5;
  // Status fields
  localparam int ST_BF = 0;
  localparam int ST_WRITE_COLLISION_FLAG = 1;
  localparam int ST_ACK_STATUS_FLAG = 2;
  localparam int ST_OVF = 3;
  localparam int ST_IRQ = 4;
  localparam int ST_BCL = 5;
  localparam int ST_START = 6;
  localparam int ST_STOP = 7;
  // Configuration fields
  localparam int CFG_EN = 0;
  // Reset values and counts
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] DIV_MIN = 8'h03;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam int MIN_TICK_GAP = 7;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ihx_req_t;
  // Host sequencer states, one-hot
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_START = 7'h02,
    S_RESTART = 7'h04,
    S_STOP = 7'h08,
    S_TX = 7'h10,
    S_RX = 7'h20,
    S_ACK = 7'h40
  } ihx_state_t;
endpackage : ihx_pkg
`default_nettype wire

// ### verilog/ihx_baud_gen.sv
// Baud generator: reloads from the divider and pulses once per bus half period
`default_nettype none
module ihx_baud_gen #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Control
  input wire logic i_run,
  input wire logic [DIV_W-1:0] i_div,
  // Rollover
  output logic o_tick
);
  logic [DIV_W:0] cnt_q;
  logic [DIV_W-1:0] div_eff;
  logic [DIV_W:0] reload;

  // Divider values below the minimum are unusable, so they run as the minimum
  assign div_eff = (i_div < DIV_W'(ihx_pkg::DIV_MIN)) ? DIV_W'(ihx_pkg::DIV_MIN) : i_div;
  // Half period is 2*(div+1) clocks, so a full bus clock is osc/(4*(div+1))
  assign reload = {div_eff, 1'b1};
  assign o_tick = i_run && (cnt_q == '0);

  // Count down while running; a stopped generator sits at its reload value
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || !i_run || o_tick)
      cnt_q <= reload;
    else
      cnt_q <= cnt_q - 1'b1;
  end

  chk_tick_spacing: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_tick |=> !o_tick [*7])
    else $error("baud rollovers closer than the minimum half period");
endmodule : ihx_baud_gen
`default_nettype wire

// ### tb/ihx_client.sv
// Behavioural two-wire client: acknowledges bytes and returns one byte on reads
`default_nettype none
module ihx_client (
  // Bus lines
  input wire logic i_scl,
  input wire logic i_sda,
  // Byte returned on reads
  input wire logic [7:0] i_byte,
  // High pulls the data line low
  output logic o_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = -1;
  logic addr = 1'b1;
  logic rw = 1'b0;
  // Start or restart seen: next byte is an address
  always @(negedge i_sda)
  begin
    if (i_scl)
    begin
      cnt = -1;
      addr = 1'b1;
    end
  end
  // Falling clock moves to the next bit; the ninth wraps to a new byte
  always @(negedge i_scl)
  begin
    if (cnt == 8) addr = 1'b0;
    cnt = (cnt == 8) ? 0 : cnt + 1;
  end
  // Direction from the last address bit; a host NACK ends our sending
  always @(posedge i_scl)
  begin
    if (addr && cnt == 7) rw = i_sda;
    if (!addr && rw && cnt == 8 && i_sda) rw = 1'b0;
  end
  // Only pulls low or releases, never drives high
  assign o_pull = (cnt == 8) ? (addr || !rw) : (!addr && rw && cnt >= 0 && !i_byte[7 - cnt]);
endmodule : ihx_client
`default_nettype wire

// ### tb/ihx_top_test.sv
// Self-checking bench of the two-wire host byte engine
`default_nettype none
module ihx_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  ihx_pkg::ihx_req_t req = '0;
  logic [7:0] o_rdata;
  logic scl_oe, sda_oe, irq, bcl, c_pull, scl, sda, scl_o, sda_o;
  logic hog = 1'b0;
  logic [7:0] cbyte = 8'h00;
  logic [7:0] v;
  logic [31:0] seed = 32'h1AF49A06;
  logic bits[$];
  int ts[$];
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  // Pull-up wires; the hog is a rival host pulling data while clock is high
  assign scl = (scl_oe !== 1'b1);
  assign sda = !(sda_oe === 1'b1 || c_pull || (hog && scl));
  ihx_top dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_req(req), .o_rdata(o_rdata), .i_scl(scl),
    .o_scl(scl_o), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda(sda_o), .o_sda_oe(sda_oe), .o_serial_irq_flag(irq),
    .o_bus_collision_flag(bcl));
  ihx_client client (.i_scl(scl), .i_sda(sda), .i_byte(cbyte), .o_pull(c_pull));
  initial forever #4 i_ref_clk = !i_ref_clk;
  // Wire model: each rising bus clock captures one bit
  always @(posedge scl) bits.push_back(sda);
  // Rising-edge times give the bus clock period
  always @(posedge scl) ts.push_back(int'($time));
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // Hang guard, far above the thousand or so cycles the run needs
  always @(posedge i_ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_ref_clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_ref_clk) req <= '0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge i_ref_clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_ref_clk) req <= '0;
    @(negedge i_ref_clk) chk(o_rdata & m, exp);
  endtask : rd
  // Bounded wait for the serial flag, then clear it
  task automatic wait_irq();
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(negedge i_ref_clk);
    chk({7'h00, irq}, 8'h01);
    wr(ihx_pkg::A_STAT, 8'h10);
  endtask : wait_irq
  // One byte out, then wire bits and acknowledge against the model
  task automatic tx(input logic [7:0] d);
    bits = {};
    ts = {};
    wr(ihx_pkg::A_DATA, d);
    wait_irq();
    for (int k = 0; k < 8; k++) v[7 - k] = bits[k];
    chk(v, d);
    chk(8'((ts[1] - ts[0]) / 8), 8'(4 * (ihx_pkg::DIV_MIN + 1)));
    chk({7'h00, bits[8]}, 8'h00);
    rd(ihx_pkg::A_STAT, 8'h07, 8'h00);
  endtask : tx
  initial
  begin
    repeat (6) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    rd(ihx_pkg::A_STAT, 8'hFF, 8'h00);
    rd(ihx_pkg::A_DIV, 8'hFF, ihx_pkg::DIV_RST);
    rd(3'h7, 8'hFF, 8'h00);
    wr(ihx_pkg::A_CFG, 8'h01);
    wr(ihx_pkg::A_DIV, ihx_pkg::DIV_MIN);
    wr(ihx_pkg::A_CTRL2, 8'h01);
    wait_irq();
    rd(ihx_pkg::A_STAT, 8'hC0, 8'h40);
    wr(ihx_pkg::A_DATA, 8'hA0);
    wr(ihx_pkg::A_DATA, 8'h11);
    // Receive request while the address is still shifting must be ignored
    wr(ihx_pkg::A_CTRL2, 8'h08);
    rd(ihx_pkg::A_CTRL2, 8'hFF, 8'h00);
    rd(ihx_pkg::A_STAT, 8'h03, 8'h03);
    wr(ihx_pkg::A_STAT, 8'h02);
    wait_irq();
    seed = lfsr(seed);
    tx(seed[7:0]);
    wr(ihx_pkg::A_CTRL2, 8'h02);
    wait_irq();
    seed = lfsr(seed);
    cbyte = seed[7:0];
    tx(8'hA1);
    // Two bytes in without reading: the second one overflows
    wr(ihx_pkg::A_CTRL2, 8'h08);
    wait_irq();
    rd(ihx_pkg::A_STAT, 8'h09, 8'h01);
    wr(ihx_pkg::A_CTRL2, 8'h10);
    wait_irq();
    wr(ihx_pkg::A_CTRL2, 8'h08);
    wait_irq();
    rd(ihx_pkg::A_STAT, 8'h09, 8'h09);
    rd(ihx_pkg::A_DATA, 8'hFF, cbyte);
    rd(ihx_pkg::A_STAT, 8'h01, 8'h00);
    wr(ihx_pkg::A_CTRL2, 8'h30);
    wait_irq();
    wr(ihx_pkg::A_CTRL2, 8'h04);
    wait_irq();
    rd(ihx_pkg::A_STAT, 8'h80, 8'h80);
    // Rival host wins arbitration on the first released bit
    wr(ihx_pkg::A_CTRL2, 8'h01);
    wait_irq();
    @(posedge i_ref_clk) hog <= 1'b1;
    wr(ihx_pkg::A_DATA, 8'hFF);
    for (int i = 0; i < 3000 && bcl !== 1'b1; i++) @(negedge i_ref_clk);
    @(posedge i_ref_clk) hog <= 1'b0;
    @(negedge i_ref_clk) chk({4'h0, scl_o, sda_o, scl_oe, sda_oe}, 8'h00);
    rd(ihx_pkg::A_STAT, 8'h21, 8'h20);
    wait_irq();
    wr(ihx_pkg::A_STAT, 8'h20);
    wr(ihx_pkg::A_CTRL2, 8'h01);
    wait_irq();
    tx(8'hA0);
    test_done();
  end
endmodule : ihx_top_test
`default_nettype wire
